/* dv/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end

module tb;
    logic                  aclk = 1'h0;
    logic                  aresetn = 1'h0;
    logic [15:0]           s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
    logic [31:0]           s_axi_wdata = 32'h0, s_axi_rdata, calibration_word, v;
    logic [3:0]            s_axi_wstrb = 4'hF;
    logic                  s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic                  s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]            s_axi_bresp, s_axi_rresp, r, b;
    atfc_pkg::atfc_res_in_s res_in = '0;
    logic                  turbo_setup_fail = 1'h0, idle_req = 1'h0;
    logic                  unit_run, turbo_active, fraction_format_select;
    logic [5:0]            turbo_lead_onehot, turbo_follower_onehot;
    atfc_pkg::atfc_res_e   shared_conv_resolution;
    int                    err_count = 0, checked = 0;

    atfc_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .res_in, .turbo_setup_fail, .idle_req, .unit_run, .turbo_active,
        .turbo_lead_onehot, .turbo_follower_onehot, .fraction_format_select,
        .shared_conv_resolution, .calibration_word);

    always #4 aclk = ~aclk;

    // ------------------------------------------------------------------
    // Bus and stimulus tasks
    // ------------------------------------------------------------------
    // Ready is sampled in the same loop as the response, because the
    // response can be taken at the very edge after the last channel.
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        b = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] rr);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    task automatic crd(input logic [15:0] a, input logic [31:0] e);
        rd(a, v, r);
        `CHK(v, e)
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask

    task automatic put(input logic [5:0] id, input logic [11:0] raw);
        @(posedge aclk);
        res_in <= {1'h1, id, raw};
        @(posedge aclk);
        res_in <= '0;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        crd(16'h7000, 32'h0060_0000);
        crd(16'h7840, 32'h0000_0000);
        `CHK(shared_conv_resolution, 2'h3)
        `CHK(unit_run, 1'h0)
        crd(16'h7010, 32'h0000_0000);
        `CHK(r, 2'h3)
        wr(16'h7010, 32'hFFFF_FFFF);
        `CHK(b, 2'h3)
        crd(16'h7000, 32'h0060_0000);
    endtask

    task automatic t_mask;
        wr(16'h7000, 32'hFFFF_FFFF);
        `CHK(b, 2'h0)
        crd(16'h7000, 32'hFFFF_BE7F);
        wt(1);
        `CHK(turbo_active, 1'h0)
        `CHK(turbo_lead_onehot, 6'h00)
        `CHK(turbo_follower_onehot, 6'h00)
    endtask

    task automatic t_decode;
        for (int c = 0; c < 8; c++) begin
            wr(16'h7000, 32'h0060_0000 | (32'(c) << 27) | (32'(c) << 24));
            wt(2);
            `CHK(turbo_lead_onehot, (c < 6) ? 6'h01 << c : 6'h00)
            `CHK(turbo_follower_onehot, (c < 6) ? 6'h01 << c : 6'h00)
        end
    endtask

    task automatic t_turbo;
        wr(16'h7D00, 32'h1234_5678);
        crd(16'h7D00, 32'h1234_5678);
        wr(16'h7000, 32'h9460_0000);
        wr(16'h7000, 32'h9460_8000);
        wt(2);
        `CHK(turbo_active, 1'h1)
        `CHK(turbo_follower_onehot, 6'h10)
        `CHK(calibration_word, 32'h1234_5678)
        crd(16'h7000, 32'h9460_8000);
        @(posedge aclk);
        turbo_setup_fail <= 1'h1;
        @(posedge aclk);
        turbo_setup_fail <= 1'h0;
        wt(2);
        `CHK(turbo_active, 1'h0)
        crd(16'h7000, 32'hD460_8000);
        wr(16'h7000, 32'h1460_8000);
        wr(16'h7000, 32'h9460_8000);
        wt(2);
        `CHK(turbo_active, 1'h1)
        wr(16'h7000, 32'h1460_8000);
        wt(2);
        `CHK(turbo_active, 1'h0)
    endtask

    task automatic t_result;
        logic [31:0] m, e;
        for (int f = 0; f < 2; f++) for (int c = 0; c < 4; c++) begin
            wr(16'h7000, 32'h0000_8000 | (32'(f) << 23) | (32'(c) << 21));
            put(6'h2D, 12'hABC);
            m = 32'h0000_0ABC & ((32'h1 << (6 + 2 * c)) - 32'h1);
            e = (f != 0) ? m << (10 - 2 * c) : m;
            crd(16'h78D0, e);
            `CHK(shared_conv_resolution, 2'(c))
            `CHK(fraction_format_select, 1'(f))
        end
        wr(16'h78D0, 32'hFFFF_FFFF);
        crd(16'h78D0, e);
        wr(16'h7000, 32'h0060_0000);
        put(6'h2D, 12'h111);
        crd(16'h78D0, e);
        wr(16'h7000, 32'h0060_8000);
        put(6'h35, 12'h5A5);
        crd(16'h7950, 32'h0000_05A5);
    endtask

    task automatic t_idle;
        idle_req <= 1'h1;
        wt(5);
        `CHK(unit_run, 1'h1)
        wr(16'h7000, 32'h0060_A000);
        wt(5);
        `CHK(unit_run, 1'h0)
        @(posedge aclk);
        idle_req <= 1'h0;
        wt(5);
        `CHK(unit_run, 1'h1)
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset;
        t_mask;
        t_decode;
        t_turbo;
        t_result;
        t_idle;
        give_verdict;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        give_verdict;
    end
endmodule // tb

`default_nettype wire

/* include/atfc_map.svh */
`ifndef ATFC_MAP_SVH
`define ATFC_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ATFC_CTRL1_OFS      16'h7000
`define ATFC_STATUS_OFS     16'h7004
`define ATFC_RES36_OFS      16'h7840
`define ATFC_RES37_OFS      16'h7850
`define ATFC_RES38_OFS      16'h7860
`define ATFC_RES39_OFS      16'h7870
`define ATFC_RES40_OFS      16'h7880
`define ATFC_RES41_OFS      16'h7890
`define ATFC_RES45_OFS      16'h78D0
`define ATFC_RES46_OFS      16'h78E0
`define ATFC_RES47_OFS      16'h78F0
`define ATFC_RES48_OFS      16'h7900
`define ATFC_RES49_OFS      16'h7910
`define ATFC_RES50_OFS      16'h7920
`define ATFC_RES52_OFS      16'h7940
`define ATFC_RES53_OFS      16'h7950
`define ATFC_CAL0_OFS       16'h7D00
`define ATFC_PRES0_OFS      16'h7E00
`define ATFC_PRES1_OFS      16'h7E10

// ----------------------------------------------------------------------------
// Field positions, masks and reset values
// ----------------------------------------------------------------------------
`define ATFC_TRB_EN_BIT     31
`define ATFC_CTRL1_RST      32'h0060_0000
`define ATFC_CTRL1_WMASK    32'hBFFF_BE7F
`define ATFC_CTRL1_RMASK    32'hFFFF_BE7F
`define ATFC_CAL0_RST       32'h0000_0000
`define ATFC_RESULT_RST     32'h0000_0000
`define ATFC_PRES0_RST      32'h0FFF_FFFF
`define ATFC_PRES1_RST      32'h0037_E3FE
`define ATFC_CONV_CODE_MAX  3'h5
`define ATFC_RESP_OKAY      2'h0
`define ATFC_RESP_DECERR    2'h3

`endif

/* include/atfc_pkg.sv */
package atfc_pkg;

    typedef enum logic [1:0] {
        atfc_res_6,
        atfc_res_8,
        atfc_res_10,
        atfc_res_12
    } atfc_res_e;

    typedef struct packed {
        logic       turbo_pair_enable;
        logic       turbo_pair_fault;
        logic [2:0] turbo_lead_select;
        logic [2:0] turbo_follower_select;
        logic       fraction_format_select;
        atfc_res_e  shared_conv_resolution;
        logic [4:0] scan_trigger_source;
        logic       unit_on;
        logic       pad14;
        logic       idle_stop;
        logic       charge_pump_en;
        logic       cvd_en;
        logic       dma_clk_bypass;
        logic       bus_clk_bypass;
        logic [1:0] pad8_7;
        logic [2:0] vector_shift;
        logic       scan_level;
        logic [2:0] dma_buf_len;
    } atfc_ctrl_s;

    typedef struct packed {
        logic        valid;
        logic [5:0]  input_id;
        logic [11:0] raw;
    } atfc_res_in_s;

endpackage

/* verilog/atfc_result_mem.sv */
`timescale 1ns/10ps
`default_nettype none

module atfc_result_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 14,
    parameter int AW    = 4
) (
    input  wire logic             aclk,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    if (DEPTH > (1 << AW)) begin : g_chk
        $error("atfc_result_mem: DEPTH does not fit AW");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];

    // The array has no reset; the owner keeps a valid bit per word instead.
    always_ff @(posedge aclk) begin
        if (wr_en && (int'(wr_addr) < DEPTH)) begin
            mem_ff[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge aclk) begin
        rd_data <= (int'(rd_addr) < DEPTH) ? mem_ff[rd_addr] : '0;
    end

endmodule // atfc_result_mem

`default_nettype wire

/* verilog/atfc_top.sv */
// How it works
// - Writing the turbo enable bit to one pairs two converters while the unit runs, and writing it to zero unpairs them.
// - Hardware sets the read-only turbo fault flag when pairing setup fails, and turbo stays off while it is set.
// - Lead select codes 0 to 5 pick converters 0 to 5 and codes 6 and 7 are reserved.
// - Follower select codes decode the same way, with 6 and 7 reserved.
// - Results are fractional when the format bit is one and integer when it is zero, the reset state.
// - The shared converter resolution code 3, 2, 1, 0 gives 12, 10, 8, 6 bits, with 12 bits after reset.
// - Unimplemented control bits read as zero and ignore writes.
// - The unit runs while the module enable bit is one and is held off while it is zero.
// - With stop-in-idle set the unit halts in idle mode, otherwise it keeps running.
`timescale 1ns/10ps
`default_nettype none
`include "atfc_map.svh"

module atfc_top #(
    parameter int          ADDR_W    = 16,
    parameter logic [31:0] PRES0_VAL = `ATFC_PRES0_RST,
    parameter logic [31:0] PRES1_VAL = `ATFC_PRES1_RST
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire atfc_pkg::atfc_res_in_s res_in,
    input  wire logic                 turbo_setup_fail,
    input  wire logic                 idle_req,
    output logic                      unit_run,
    output logic                      turbo_active,
    output logic [5:0]                turbo_lead_onehot,
    output logic [5:0]                turbo_follower_onehot,
    output logic                      fraction_format_select,
    output atfc_pkg::atfc_res_e       shared_conv_resolution,
    output logic [31:0]               calibration_word
);

    if (ADDR_W < 16) begin : g_chk
        $error("atfc_top: ADDR_W must be at least 16");
    end

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [4:0] res_slot(input logic [15:0] a);
        case (a)
            `ATFC_RES36_OFS: res_slot = 5'h00;
            `ATFC_RES37_OFS: res_slot = 5'h01;
            `ATFC_RES38_OFS: res_slot = 5'h02;
            `ATFC_RES39_OFS: res_slot = 5'h03;
            `ATFC_RES40_OFS: res_slot = 5'h04;
            `ATFC_RES41_OFS: res_slot = 5'h05;
            `ATFC_RES45_OFS: res_slot = 5'h06;
            `ATFC_RES46_OFS: res_slot = 5'h07;
            `ATFC_RES47_OFS: res_slot = 5'h08;
            `ATFC_RES48_OFS: res_slot = 5'h09;
            `ATFC_RES49_OFS: res_slot = 5'h0A;
            `ATFC_RES50_OFS: res_slot = 5'h0B;
            `ATFC_RES52_OFS: res_slot = 5'h0C;
            `ATFC_RES53_OFS: res_slot = 5'h0D;
            default:         res_slot = 5'h10;
        endcase
    endfunction

    function automatic logic is_mapped(input logic [15:0] a);
        logic [4:0] slot;
        slot      = res_slot(a);
        is_mapped = !slot[4] || (a == `ATFC_CTRL1_OFS) || (a == `ATFC_STATUS_OFS) ||
                    (a == `ATFC_CAL0_OFS) || (a == `ATFC_PRES0_OFS) || (a == `ATFC_PRES1_OFS);
    endfunction

    // Reserved codes decode to no converter at all.
    function automatic logic [5:0] conv_decode(input logic [2:0] code);
        conv_decode = (code > `ATFC_CONV_CODE_MAX) ? 6'h00 : 6'(6'h01 << code);
    endfunction

    function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        merge_strb = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge_strb[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction

    // ------------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------------
    logic              aw_held_ff;
    logic              w_held_ff;
    logic [15:0]       awaddr_ff;
    logic [31:0]       wdata_ff;
    logic [3:0]        wstrb_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              aw_take;
    logic              w_take;
    logic              wr_fire;
    logic [15:0]       wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic              ctrl_wr;
    logic              cal_wr;

    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready  = !w_held_ff && !bvalid_ff;
    assign aw_take       = s_axi_awvalid && s_axi_awready;
    assign w_take        = s_axi_wvalid && s_axi_wready;
    assign wr_fire       = (aw_held_ff || aw_take) && (w_held_ff || w_take);
    assign wr_addr       = aw_held_ff ? awaddr_ff : s_axi_awaddr[15:0];
    assign wr_data       = w_held_ff ? wdata_ff : s_axi_wdata;
    assign wr_strb       = w_held_ff ? wstrb_ff : s_axi_wstrb;
    assign ctrl_wr       = wr_fire && (wr_addr == `ATFC_CTRL1_OFS);
    assign cal_wr        = wr_fire && (wr_addr == `ATFC_CAL0_OFS);
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awaddr_ff  <= 16'h0000;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
        end else begin
            if (aw_take) begin
                awaddr_ff <= s_axi_awaddr[15:0];
            end
            if (w_take) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            aw_held_ff <= (aw_held_ff || aw_take) && !wr_fire;
            w_held_ff  <= (w_held_ff || w_take) && !wr_fire;
        end
    end

    // Writes to read-only words are dropped but still answered OKAY.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `ATFC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= is_mapped(wr_addr) ? `ATFC_RESP_OKAY : `ATFC_RESP_DECERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Control, calibration and turbo fault
    // ------------------------------------------------------------------------
    atfc_pkg::atfc_ctrl_s ctrl_ff;
    logic [31:0]          ctrl_rd;
    logic [31:0]          cal_ff;
    logic                 fault_ff;
    logic                 bad_sel;
    logic                 fault_set;
    logic                 en_rise;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= `ATFC_CTRL1_RST;
        end else if (ctrl_wr) begin
            ctrl_ff <= merge_strb(ctrl_ff, wr_data, wr_strb) & `ATFC_CTRL1_WMASK;
        end
    end

    // Calibration is plain storage; software must fill it before enabling the unit.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cal_ff <= `ATFC_CAL0_RST;
        end else if (cal_wr) begin
            cal_ff <= merge_strb(cal_ff, wr_data, wr_strb);
        end
    end

    // A lead/follower pair that is reserved or identical cannot be paired.
    assign bad_sel   = (ctrl_ff.turbo_lead_select > `ATFC_CONV_CODE_MAX) ||
                       (ctrl_ff.turbo_follower_select > `ATFC_CONV_CODE_MAX) ||
                       (ctrl_ff.turbo_lead_select == ctrl_ff.turbo_follower_select);
    assign fault_set = ctrl_ff.turbo_pair_enable && (bad_sel || turbo_setup_fail);
    assign en_rise   = ctrl_wr && wr_strb[3] && wr_data[`ATFC_TRB_EN_BIT] && !ctrl_ff.turbo_pair_enable;

    // The flag clears only on a fresh enable, so a stale value may stand while disabled.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_ff <= 1'b0;
        end else if (fault_set) begin
            fault_ff <= 1'b1;
        end else if (en_rise) begin
            fault_ff <= 1'b0;
        end
    end

    always_comb begin
        ctrl_rd     = ctrl_ff;
        ctrl_rd[30] = fault_ff;
    end

    // ------------------------------------------------------------------------
    // Run state and outputs
    // ------------------------------------------------------------------------
    logic idle_meta_ff;
    logic idle_ff;
    logic run_c;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_meta_ff <= 1'b0;
            idle_ff      <= 1'b0;
        end else begin
            idle_meta_ff <= idle_req;
            idle_ff      <= idle_meta_ff;
        end
    end

    assign run_c = ctrl_ff.unit_on && !(ctrl_ff.idle_stop && idle_ff);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unit_run               <= 1'b0;
            turbo_active           <= 1'b0;
            turbo_lead_onehot      <= 6'h00;
            turbo_follower_onehot  <= 6'h00;
            fraction_format_select <= 1'b0;
            shared_conv_resolution <= atfc_pkg::atfc_res_12;
            calibration_word       <= `ATFC_CAL0_RST;
        end else begin
            unit_run               <= run_c;
            turbo_active           <= run_c && ctrl_ff.turbo_pair_enable && !fault_ff;
            turbo_lead_onehot      <= conv_decode(ctrl_ff.turbo_lead_select);
            turbo_follower_onehot  <= conv_decode(ctrl_ff.turbo_follower_select);
            fraction_format_select <= ctrl_ff.fraction_format_select;
            shared_conv_resolution <= ctrl_ff.shared_conv_resolution;
            calibration_word       <= cal_ff;
        end
    end

    // ------------------------------------------------------------------------
    // Result capture
    // ------------------------------------------------------------------------
    logic [13:0] valid_ff;
    logic [4:0]  in_slot;
    logic        res_wr;
    logic [31:0] res_word;
    logic [3:0]  frac_sh;
    logic [11:0] raw_m;

    always_comb begin
        case (res_in.input_id)
            6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h29: in_slot = 5'(res_in.input_id - 6'h24);
            6'h2D, 6'h2E, 6'h2F, 6'h30, 6'h31, 6'h32: in_slot = 5'(res_in.input_id - 6'h27);
            6'h34, 6'h35:                             in_slot = 5'(res_in.input_id - 6'h28);
            default:                                  in_slot = 5'h10;
        endcase
    end

    // Samples arrive right-justified; fractional form moves the top bit to bit 15.
    assign frac_sh  = 4'(4'hA - {1'b0, ctrl_ff.shared_conv_resolution, 1'b0});
    assign raw_m    = res_in.raw & (12'hFFF >> 4'(4'h6 - {1'b0, ctrl_ff.shared_conv_resolution, 1'b0}));
    assign res_word = ctrl_ff.fraction_format_select ?
                      {16'h0000, 16'({4'h0, raw_m} << frac_sh)} : {20'h00000, raw_m};
    assign res_wr   = res_in.valid && !in_slot[4] && run_c;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            valid_ff <= 14'h0000;
        end else if (res_wr) begin
            valid_ff[in_slot[3:0]] <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------------
    logic        rd_stage_ff;
    logic        rvalid_ff;
    logic [15:0] rd_addr_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic [31:0] mem_q;
    logic [4:0]  rd_slot;
    logic [4:0]  ar_slot;
    logic [31:0] rd_mux;

    assign s_axi_arready = !rd_stage_ff && !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign rd_slot       = res_slot(rd_addr_ff);
    assign ar_slot       = res_slot(s_axi_araddr[15:0]);

    atfc_result_mem #(
        .WIDTH (32),
        .DEPTH (14),
        .AW    (4)
    ) u_mem (
        .aclk    (aclk),
        .wr_en   (res_wr),
        .wr_addr (in_slot[3:0]),
        .wr_data (res_word),
        .rd_addr (ar_slot[3:0]),
        .rd_data (mem_q)
    );

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (!rd_slot[4]) begin
            rd_mux = valid_ff[rd_slot[3:0]] ? mem_q : `ATFC_RESULT_RST;
        end else begin
            case (rd_addr_ff)
                `ATFC_CTRL1_OFS:  rd_mux = ctrl_rd;
                `ATFC_STATUS_OFS: rd_mux = {28'h0000000, idle_ff, fault_ff, turbo_active, unit_run};
                `ATFC_CAL0_OFS:   rd_mux = cal_ff;
                `ATFC_PRES0_OFS:  rd_mux = PRES0_VAL;
                `ATFC_PRES1_OFS:  rd_mux = PRES1_VAL;
                default:          rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_stage_ff <= 1'b0;
            rvalid_ff   <= 1'b0;
            rd_addr_ff  <= 16'h0000;
            rdata_ff    <= 32'h0000_0000;
            rresp_ff    <= `ATFC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_stage_ff <= 1'b1;
            rd_addr_ff  <= s_axi_araddr[15:0];
        end else if (rd_stage_ff) begin
            rd_stage_ff <= 1'b0;
            rvalid_ff   <= 1'b1;
            rdata_ff    <= rd_mux;
            rresp_ff    <= is_mapped(rd_addr_ff) ? `ATFC_RESP_OKAY : `ATFC_RESP_DECERR;
        end else if (s_axi_rready) begin
            rvalid_ff   <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    turbo_enable_a: assert property (ctrl_wr && wr_strb[3] |=> ctrl_ff.turbo_pair_enable == $past(wr_data[31]))
        else $error("turbo enable did not follow the write");
    fault_set_a: assert property (ctrl_ff.turbo_pair_enable && bad_sel |=> fault_ff)
        else $error("bad turbo pairing did not raise the fault");
    fault_block_a: assert property (fault_ff |=> !turbo_active)
        else $error("turbo active while fault flag set");
    lead_decode_a: assert property (ctrl_ff.turbo_lead_select > 3'h5 |=> turbo_lead_onehot == 6'h00)
        else $error("reserved lead code selected a converter");
    follow_decode_a: assert property (ctrl_ff.turbo_follower_select == 3'h5 |=> turbo_follower_onehot == 6'h20)
        else $error("follower code 5 not decoded to converter 5");
    frac_format_a: assert property (res_wr && ctrl_ff.fraction_format_select
                                    && ctrl_ff.shared_conv_resolution == atfc_pkg::atfc_res_12 |->
                                    res_word[3:0] == 4'h0 && res_word[31:16] == 16'h0000)
        else $error("fractional result not left justified");
    int_res6_a: assert property (res_wr && !ctrl_ff.fraction_format_select
                                 && ctrl_ff.shared_conv_resolution == atfc_pkg::atfc_res_6 |->
                                 res_word[31:6] == 26'h0000000)
        else $error("6-bit integer result wider than 6 bits");
    unimpl_zero_a: assert property (rvalid_ff && rd_addr_ff == `ATFC_CTRL1_OFS |->
                                    (rdata_ff & ~`ATFC_CTRL1_RMASK) == 32'h0000_0000)
        else $error("unimplemented control bit read as one");
    unit_off_a: assert property (!ctrl_ff.unit_on |=> !unit_run)
        else $error("unit running with enable clear");
    idle_stop_a: assert property (ctrl_ff.idle_stop && idle_ff |=> !unit_run && !turbo_active)
        else $error("unit running in idle with stop-in-idle set");
    result_clear_a: assert property ($rose(aresetn) |-> valid_ff == 14'h0000)
        else $error("result registers not cleared by reset");

endmodule // atfc_top

`default_nettype wire
